// file: src/wsr_pkg.sv
// Types for the watchdog/system-reset block.
// Assumes the constants header is compiled alongside.
package wsr_pkg;

   typedef enum logic [3:0] {
      WSR_RS_OFF   = 4'b0001,
      WSR_RS_DELAY = 4'b0010,
      WSR_RS_PULSE = 4'b0100,
      WSR_RS_RUN   = 4'b1000
   } wsr_rs_state_t;

   typedef enum logic [3:0] {
      WSR_WD_IDLE    = 4'b0001,
      WSR_WD_INIT    = 4'b0010,
      WSR_WD_COUNT   = 4'b0100,
      WSR_WD_EXPIRED = 4'b1000
   } wsr_wd_state_t;

endpackage : wsr_pkg

// file: src/wsr_regs.svh
// Register offsets, field positions, reset values and timing counts for the
// watchdog/system-reset block. Assumes a word-aligned plain register port.
`ifndef WSR_REGS_SVH
`define WSR_REGS_SVH

`define WSR_OFF_CTRL        8'h00
`define WSR_OFF_DELAY       8'h04
`define WSR_OFF_PULSE_W     8'h08
`define WSR_OFF_WD_INIT     8'h0C
`define WSR_OFF_WD_TIMEOUT  8'h10
`define WSR_OFF_KICK        8'h14
`define WSR_OFF_STATUS      8'h18

`define WSR_CTRL_RST_EN     0
`define WSR_CTRL_PULSE      1
`define WSR_CTRL_WD_EN      2
`define WSR_CTRL_WD_LINK    3
`define WSR_CTRL_KICK_PIN   4
`define WSR_CTRL_EXP_PIN    5
`define WSR_CTRL_W          6

`define WSR_ST_RST_ASSERTED 0
`define WSR_ST_EXPIRED      1
`define WSR_ST_WD_RUN       2
`define WSR_ST_RAILS_GOOD   3

`define WSR_CTRL_RST        6'h00
`define WSR_DELAY_RST       5'h00
`define WSR_PULSE_W_RST     16'h0001
`define WSR_WD_INIT_RST     4'h0
`define WSR_WD_TIMEOUT_RST  16'h0001

`define WSR_DELAY_IDX_MAX   5'h10
`define WSR_INIT_IDX_MAX    4'hF
`define WSR_MS_MIN          16'h0001
`define WSR_MS_MAX          16'h7E00
`define WSR_INIT_BASE_MS    21'h000064

`define WSR_CLK_PERIOD_NS   40
`define WSR_MS_NS           1000000
`define WSR_TICK_CYCLES     (`WSR_MS_NS / `WSR_CLK_PERIOD_NS)

`endif

// file: src/wsr_watchdog_system_reset.sv
// System-reset generator with supervision timer, register port and kick pin.
// Assumes all inputs synchronous to ref_clk_i except kick_input_i, which is synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "wsr_regs.svh"

// Summary of operation
// RQ1 - Reset output held until selected rails good, then programmable delay before change.
// RQ2 - Delay chosen from seventeen settings: zero, then 1 ms doubling to 32.8 s.
// RQ3 - Level mode: release after rails good plus delay, reassert on power-good-off.
// RQ4 - Pulse mode: one reset pulse after delay, width 1 ms to 32256 ms.
// RQ5 - Supervision timer uses one kick input and one expiry output, optionally reset-linked.
// RQ6 - Kick pin toggle or kick register write restarts the timeout count.
// RQ7 - Kick pin and expiry pin are optional; command-only service and reset expiry allowed.
// RQ8 - Initial wait before first timeout: zero, or 100 ms doubling to 1638 s.
// RQ9 - Timeout programmable from 1 ms to 32256 ms.
// RQ10 - On timeout assert expiry output or pulse system reset, per configuration.
// RQ11 - After timeout stay expired until kick pin toggle or kick command restarts it.
// RQ12 - Linked: reset releases after rails good; unserviced expiry toggles reset again.
// RQ13 - Kick input synchronised; any transition counts as a service event.
// RQ14 - Timings counted in 1 ms steps from a millisecond tick.
module wsr_watchdog_system_reset #(
   parameter int TICK_CYCLES = `WSR_TICK_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   output logic [31:0] rd_data_o,
   // Rail status
   input wire logic rails_pg_on_i,
   input wire logic rails_pg_off_i,
   // Host link
   input wire logic kick_input_i,
   output logic sys_reset_n_o,
   output logic expiry_output_o
);

   // Millisecond tick
   logic [15:0] tick_cnt_r, tick_cnt_nxt;
   logic tick;

   assign tick = (tick_cnt_r == 16'(TICK_CYCLES - 1)); // RQ14

   always_comb begin
      tick_cnt_nxt = tick ? 16'h0000 : tick_cnt_r + 16'h0001;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_cnt_r <= 16'h0000;
      end else begin
         tick_cnt_r <= tick_cnt_nxt;
      end
   end

   // Kick pin synchroniser; first stage feeds only the second
   logic kick_s1_r, kick_s2_r, kick_s3_r;
   logic kick_pin_evt;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         kick_s1_r <= 1'b0;
         kick_s2_r <= 1'b0;
         kick_s3_r <= 1'b0;
      end else begin
         kick_s1_r <= kick_input_i; // RQ13
         kick_s2_r <= kick_s1_r;
         kick_s3_r <= kick_s2_r;
      end
   end

   assign kick_pin_evt = kick_s2_r ^ kick_s3_r; // RQ13

   // Registers
   logic [`WSR_CTRL_W-1:0] ctrl_r, ctrl_nxt;
   logic [4:0] delay_idx_r, delay_idx_nxt;
   logic [15:0] pulse_w_r, pulse_w_nxt;
   logic [3:0] init_idx_r, init_idx_nxt;
   logic [15:0] timeout_r, timeout_nxt;
   logic [31:0] rd_data_nxt;
   logic kick_cmd;
   logic kick_evt;
   logic [3:0] status;

   // Out-of-range settings are clamped, so software cannot select a zero-width pulse
   function automatic logic [15:0] wsr_clamp_ms(input logic [31:0] v);
      if (v[15:0] < `WSR_MS_MIN || v[31:16] != 16'h0000) begin
         wsr_clamp_ms = (v[31:16] != 16'h0000) ? `WSR_MS_MAX : `WSR_MS_MIN;
      end else if (v[15:0] > `WSR_MS_MAX) begin
         wsr_clamp_ms = `WSR_MS_MAX;
      end else begin
         wsr_clamp_ms = v[15:0];
      end
   endfunction : wsr_clamp_ms

   assign kick_cmd = wr_en_i && (addr_i == `WSR_OFF_KICK);
   assign kick_evt = kick_cmd || (ctrl_r[`WSR_CTRL_KICK_PIN] && kick_pin_evt); // RQ6 RQ7

   always_comb begin
      ctrl_nxt = ctrl_r;
      delay_idx_nxt = delay_idx_r;
      pulse_w_nxt = pulse_w_r;
      init_idx_nxt = init_idx_r;
      timeout_nxt = timeout_r;
      rd_data_nxt = 32'h00000000;
      if (wr_en_i) begin
         case (addr_i)
            `WSR_OFF_CTRL: ctrl_nxt = wr_data_i[`WSR_CTRL_W-1:0];
            `WSR_OFF_DELAY: begin
               delay_idx_nxt = (wr_data_i[4:0] > `WSR_DELAY_IDX_MAX) ? `WSR_DELAY_IDX_MAX : wr_data_i[4:0]; // RQ2
            end
            `WSR_OFF_PULSE_W: pulse_w_nxt = wsr_clamp_ms(wr_data_i); // RQ4
            `WSR_OFF_WD_INIT: init_idx_nxt = wr_data_i[3:0]; // RQ8
            `WSR_OFF_WD_TIMEOUT: timeout_nxt = wsr_clamp_ms(wr_data_i); // RQ9
            default: ;
         endcase
      end
      if (rd_en_i) begin
         case (addr_i)
            `WSR_OFF_CTRL: rd_data_nxt = {26'h0000000, ctrl_r};
            `WSR_OFF_DELAY: rd_data_nxt = {27'h0000000, delay_idx_r};
            `WSR_OFF_PULSE_W: rd_data_nxt = {16'h0000, pulse_w_r};
            `WSR_OFF_WD_INIT: rd_data_nxt = {28'h0000000, init_idx_r};
            `WSR_OFF_WD_TIMEOUT: rd_data_nxt = {16'h0000, timeout_r};
            `WSR_OFF_STATUS: rd_data_nxt = {28'h0000000, status};
            default: rd_data_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_r <= `WSR_CTRL_RST;
         delay_idx_r <= `WSR_DELAY_RST;
         pulse_w_r <= `WSR_PULSE_W_RST;
         init_idx_r <= `WSR_WD_INIT_RST;
         timeout_r <= `WSR_WD_TIMEOUT_RST;
         rd_data_o <= 32'h00000000;
      end else begin
         ctrl_r <= ctrl_nxt;
         delay_idx_r <= delay_idx_nxt;
         pulse_w_r <= pulse_w_nxt;
         init_idx_r <= init_idx_nxt;
         timeout_r <= timeout_nxt;
         rd_data_o <= rd_data_nxt;
      end
   end

   // Setting lookups
   logic [15:0] delay_ms;
   logic [20:0] init_ms;

   assign delay_ms = (delay_idx_r == 5'h00) ? 16'h0000 : (16'h0001 << (delay_idx_r - 5'h01)); // RQ2
   assign init_ms = (init_idx_r == 4'h0) ? 21'h000000 : (`WSR_INIT_BASE_MS << (init_idx_r - 4'h1)); // RQ8

   // Supervision timer
   wsr_pkg::wsr_wd_state_t wd_st_r, wd_st_nxt;
   logic [20:0] wd_cnt_r, wd_cnt_nxt;
   logic wd_active;
   logic wd_fire;
   logic linked;
   wsr_pkg::wsr_rs_state_t rs_st_r, rs_st_nxt;

   assign linked = ctrl_r[`WSR_CTRL_WD_LINK];
   // Linked timer only runs while the host is out of reset
   assign wd_active = ctrl_r[`WSR_CTRL_WD_EN] && (!linked || rs_st_r == wsr_pkg::WSR_RS_RUN); // RQ5 RQ12
   // Fires on the tick after the count empties, so a free-running tick never cuts the timeout short
   assign wd_fire = (wd_st_r == wsr_pkg::WSR_WD_COUNT) && tick && (wd_cnt_r == 21'h000000) && !kick_evt; // RQ9

   always_comb begin
      wd_st_nxt = wd_st_r;
      wd_cnt_nxt = wd_cnt_r;
      case (wd_st_r)
         wsr_pkg::WSR_WD_IDLE: begin
            if (wd_active) begin
               wd_st_nxt = wsr_pkg::WSR_WD_INIT; // RQ8
               wd_cnt_nxt = init_ms;
            end
         end
         wsr_pkg::WSR_WD_INIT: begin
            if (wd_cnt_r == 21'h000000) begin
               wd_st_nxt = wsr_pkg::WSR_WD_COUNT;
               wd_cnt_nxt = {5'h00, timeout_r}; // RQ9
            end else if (tick) begin
               wd_cnt_nxt = wd_cnt_r - 21'h000001; // RQ14
            end
         end
         wsr_pkg::WSR_WD_COUNT: begin
            if (kick_evt) begin
               wd_cnt_nxt = {5'h00, timeout_r}; // RQ6
            end else if (wd_fire) begin
               wd_st_nxt = wsr_pkg::WSR_WD_EXPIRED; // RQ10
               wd_cnt_nxt = 21'h000000;
            end else if (tick) begin
               wd_cnt_nxt = wd_cnt_r - 21'h000001; // RQ14
            end
         end
         wsr_pkg::WSR_WD_EXPIRED: begin
            if (kick_evt) begin
               wd_st_nxt = wsr_pkg::WSR_WD_COUNT; // RQ11
               wd_cnt_nxt = {5'h00, timeout_r};
            end
         end
         default: begin
            wd_st_nxt = wsr_pkg::WSR_WD_IDLE;
            wd_cnt_nxt = 21'h000000;
         end
      endcase
      if (!wd_active && !(linked && wd_st_r == wsr_pkg::WSR_WD_EXPIRED && ctrl_r[`WSR_CTRL_WD_EN])) begin
         wd_st_nxt = wsr_pkg::WSR_WD_IDLE;
         wd_cnt_nxt = 21'h000000;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wd_st_r <= wsr_pkg::WSR_WD_IDLE;
         wd_cnt_r <= 21'h000000;
      end else begin
         wd_st_r <= wd_st_nxt;
         wd_cnt_r <= wd_cnt_nxt;
      end
   end

   // System reset sequencer
   logic [15:0] rs_cnt_r, rs_cnt_nxt;
   logic sys_reset_n_nxt;
   logic expiry_nxt;
   logic pulse_mode;

   assign pulse_mode = ctrl_r[`WSR_CTRL_PULSE];

   always_comb begin
      rs_st_nxt = rs_st_r;
      rs_cnt_nxt = rs_cnt_r;
      case (rs_st_r)
         wsr_pkg::WSR_RS_OFF: begin
            if (ctrl_r[`WSR_CTRL_RST_EN] && rails_pg_on_i && !rails_pg_off_i) begin
               rs_st_nxt = wsr_pkg::WSR_RS_DELAY; // RQ1
               rs_cnt_nxt = delay_ms;
            end
         end
         wsr_pkg::WSR_RS_DELAY: begin
            // Extra tick covers the unknown tick phase at entry; zero delay leaves at once
            if (rs_cnt_r == 16'h0000 && (tick || delay_ms == 16'h0000)) begin
               rs_st_nxt = pulse_mode ? wsr_pkg::WSR_RS_PULSE : wsr_pkg::WSR_RS_RUN; // RQ1 RQ3 RQ4
               rs_cnt_nxt = pulse_w_r;
            end else if (tick) begin
               rs_cnt_nxt = rs_cnt_r - 16'h0001; // RQ14
            end
         end
         wsr_pkg::WSR_RS_PULSE: begin
            if (rs_cnt_r == 16'h0000 && tick) begin
               rs_st_nxt = wsr_pkg::WSR_RS_RUN; // RQ4
            end else if (tick) begin
               rs_cnt_nxt = rs_cnt_r - 16'h0001;
            end
         end
         wsr_pkg::WSR_RS_RUN: begin
            if (linked && wd_fire) begin
               rs_st_nxt = wsr_pkg::WSR_RS_PULSE; // RQ10 RQ12
               rs_cnt_nxt = pulse_w_r;
            end
         end
         default: begin
            rs_st_nxt = wsr_pkg::WSR_RS_OFF;
            rs_cnt_nxt = 16'h0000;
         end
      endcase
      if (rails_pg_off_i || !ctrl_r[`WSR_CTRL_RST_EN]) begin
         rs_st_nxt = wsr_pkg::WSR_RS_OFF; // RQ3
         rs_cnt_nxt = 16'h0000;
      end
   end

   always_comb begin
      case (rs_st_nxt)
         wsr_pkg::WSR_RS_OFF: sys_reset_n_nxt = !ctrl_r[`WSR_CTRL_RST_EN] || pulse_mode; // RQ3
         wsr_pkg::WSR_RS_DELAY: sys_reset_n_nxt = pulse_mode; // RQ1
         wsr_pkg::WSR_RS_PULSE: sys_reset_n_nxt = 1'b0; // RQ4
         wsr_pkg::WSR_RS_RUN: sys_reset_n_nxt = 1'b1;
         default: sys_reset_n_nxt = 1'b1;
      endcase
      expiry_nxt = ctrl_r[`WSR_CTRL_EXP_PIN] && (wd_st_nxt == wsr_pkg::WSR_WD_EXPIRED); // RQ7 RQ10
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rs_st_r <= wsr_pkg::WSR_RS_OFF;
         rs_cnt_r <= 16'h0000;
         sys_reset_n_o <= 1'b1;
         expiry_output_o <= 1'b0;
      end else begin
         rs_st_r <= rs_st_nxt;
         rs_cnt_r <= rs_cnt_nxt;
         sys_reset_n_o <= sys_reset_n_nxt;
         expiry_output_o <= expiry_nxt;
      end
   end

   assign status = {rails_pg_on_i && !rails_pg_off_i,
                    wd_st_r == wsr_pkg::WSR_WD_COUNT || wd_st_r == wsr_pkg::WSR_WD_INIT,
                    wd_st_r == wsr_pkg::WSR_WD_EXPIRED,
                    !sys_reset_n_o};

endmodule : wsr_watchdog_system_reset
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the watchdog/system-reset block.
// Assumes checker and host model are compiled first; 1 ms is 4 cycles here.
`timescale 1ns/1ps
`default_nettype none
`include "wsr_regs.svh"
module tb;
   typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} wsr_row_t;
   logic ref_clk, rst_n, wr, rd, pg_on, pg_off, kick_req, kick_pin, sys_rst_n, expiry;
   logic [7:0] addr;
   logic [31:0] wdata, rdata;
   int miscompares = 0;
   int tests_run = 0;
   int cyc = 0;
   int n;
   wsr_row_t rows[14] = '{
      '{8'h00, 0, 32'h0, 32'h0}, '{8'h04, 0, 32'h0, 32'h0}, '{8'h08, 0, 32'h0, 32'h1},
      '{8'h0C, 0, 32'h0, 32'h0}, '{8'h10, 0, 32'h0, 32'h1}, '{8'h18, 0, 32'h0, 32'h0},
      '{8'h04, 1, 32'h14, 32'h10},
      '{8'h08, 1, 32'h0, 32'h1}, '{8'h08, 1, 32'hFFFF, 32'h7E00},
      '{8'h10, 1, 32'h0, 32'h1}, '{8'h10, 1, 32'h9000, 32'h7E00},
      '{8'h0C, 1, 32'h5, 32'h5},
      '{8'h14, 1, 32'h1, 32'h0}, '{8'hFC, 1, 32'hFF, 32'h0}};
   wsr_watchdog_system_reset #(.TICK_CYCLES(4)) uut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .addr_i(addr),
      .wr_data_i(wdata), .wr_en_i(wr), .rd_en_i(rd), .rd_data_o(rdata), .rails_pg_on_i(pg_on),
      .rails_pg_off_i(pg_off), .kick_input_i(kick_pin), .sys_reset_n_o(sys_rst_n), .expiry_output_o(expiry));
   wsr_host_model host (.ref_clk_i(ref_clk), .sys_reset_n_i(sys_rst_n), .kick_req_i(kick_req),
      .kick_pin_o(kick_pin));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic idle(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask : idle
   // Waits up to lim cycles for the chosen output to reach v, then compares
   task automatic chk(input bit which, input logic v, input int lim);
      int k;
      // Step off the edge so outputs launched by it have settled
      #1;
      k = 0;
      while (((which ? expiry : sys_rst_n) !== v) && k < lim) begin
         idle(1);
         k++;
      end
      cmp({31'h0, which ? expiry : sys_rst_n}, {31'h0, v});
   endtask : chk
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 cmp(rdata, e);
   endtask : rreg
   task automatic rails(input logic on, input logic off);
      @(posedge ref_clk);
      pg_on <= on;
      pg_off <= off;
   endtask : rails
   task automatic kick();
      @(posedge ref_clk);
      kick_req <= 1'b1;
      @(posedge ref_clk);
      kick_req <= 1'b0;
   endtask : kick
   task automatic test_done();
      $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // Whole run is about 700 cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         test_done();
      end
   end
   initial begin
      {rst_n, wr, rd, pg_on, kick_req} = 5'h00;
      pg_off = 1'b1;
      addr = 8'h00;
      wdata = 32'h0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      idle(1);
      chk(0, 1'b1, 0);
      chk(1, 1'b0, 0);
      foreach (rows[i]) begin
         if (rows[i].w) wreg(rows[i].a, rows[i].d);
         rreg(rows[i].a, rows[i].e);
      end
      $display("register table done");
      wreg(`WSR_OFF_DELAY, 32'h0);
      wreg(`WSR_OFF_CTRL, 32'h01);
      chk(0, 1'b0, 4);
      rails(1'b1, 1'b0);
      idle(1);
      chk(0, 1'b0, 0);
      chk(0, 1'b1, 3);
      rreg(`WSR_OFF_STATUS, 32'h8);
      rails(1'b0, 1'b1);
      chk(0, 1'b0, 3);
      wreg(`WSR_OFF_DELAY, 32'h3);
      rails(1'b1, 1'b0);
      idle(16);
      chk(0, 1'b0, 0);
      chk(0, 1'b1, 12);
      rails(1'b0, 1'b1);
      $display("level mode done");
      wreg(`WSR_OFF_PULSE_W, 32'h2);
      wreg(`WSR_OFF_DELAY, 32'h0);
      wreg(`WSR_OFF_CTRL, 32'h03);
      rails(1'b1, 1'b0);
      chk(0, 1'b0, 8);
      n = 0;
      while (sys_rst_n === 1'b0 && n < 40) begin
         idle(1);
         n++;
      end
      cmp({31'h0, n >= 8 && n <= 12}, 32'h1);
      $display("pulse mode done");
      wreg(`WSR_OFF_WD_INIT, 32'h1);
      wreg(`WSR_OFF_WD_TIMEOUT, 32'h3);
      wreg(`WSR_OFF_CTRL, 32'h25);
      idle(380);
      chk(1, 1'b0, 0);
      chk(1, 1'b1, 60);
      idle(40);
      chk(1, 1'b1, 0);
      rreg(`WSR_OFF_STATUS, 32'hA);
      wreg(`WSR_OFF_KICK, 32'h1);
      chk(1, 1'b0, 2);
      repeat (4) begin
         idle(6);
         wreg(`WSR_OFF_KICK, 32'h0);
      end
      chk(1, 1'b0, 0);
      chk(1, 1'b1, 24);
      kick();
      idle(8);
      chk(1, 1'b1, 0);
      wreg(`WSR_OFF_CTRL, 32'h35);
      kick();
      chk(1, 1'b0, 8);
      $display("watchdog done");
      wreg(`WSR_OFF_CTRL, 32'h0D);
      chk(0, 1'b0, 450);
      chk(0, 1'b1, 16);
      chk(1, 1'b0, 0);
      $display("linked reset done");
      test_done();
   end
endmodule : tb
bind wsr_watchdog_system_reset wsr_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.ref_clk_i(ref_clk_i),
   .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
   .rd_data_o(rd_data_o), .rails_pg_on_i(rails_pg_on_i), .rails_pg_off_i(rails_pg_off_i),
   .kick_input_i(kick_input_i), .sys_reset_n_o(sys_reset_n_o), .expiry_output_o(expiry_output_o));
`default_nettype wire

// file: testbench/wsr_checker.sv
// Port checker for the watchdog/system-reset block.
// Assumes one clock domain; attached by bind from the bench.
`timescale 1ns/1ps
`default_nettype none
`include "wsr_regs.svh"
module wsr_checker #(
   parameter int TICK_CYCLES = 4
) (
   // Clock, reset and register port
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [31:0] rd_data_o,
   // Rails and host link
   input wire logic rails_pg_on_i,
   input wire logic rails_pg_off_i,
   input wire logic kick_input_i,
   input wire logic sys_reset_n_o,
   input wire logic expiry_output_o
);
   logic [5:0] ctrl_r;
   logic [3:0] age_r;
   logic kick_d_r;
   logic kick_w;
   logic ok_w;
   logic rst_d_r;
   logic [31:0] low_cnt_r;
   logic [15:0] pw_r;
   assign kick_w = wr_en_i && addr_i == `WSR_OFF_KICK;
   assign ok_w = rails_pg_on_i && !rails_pg_off_i;
   // Age since any service or control change; saturates so it never wraps
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_r <= 6'h00;
         age_r <= 4'hF;
         kick_d_r <= 1'b0;
         rst_d_r <= 1'b1;
         low_cnt_r <= 32'h00000000;
         pw_r <= `WSR_PULSE_W_RST;
      end else begin
         kick_d_r <= kick_input_i;
         rst_d_r <= sys_reset_n_o;
         if (wr_en_i && addr_i == `WSR_OFF_PULSE_W) begin
            if (wr_data_i < 32'(`WSR_MS_MIN)) begin
               pw_r <= `WSR_MS_MIN;
            end else if (wr_data_i > 32'(`WSR_MS_MAX)) begin
               pw_r <= `WSR_MS_MAX;
            end else begin
               pw_r <= wr_data_i[15:0];
            end
         end
         // Counts only lows that began as a pulse-mode fall
         if (sys_reset_n_o) begin
            low_cnt_r <= 32'h00000000;
         end else if ((rst_d_r && ctrl_r[1]) || low_cnt_r != 32'h00000000) begin
            low_cnt_r <= low_cnt_r + 32'h00000001;
         end
         if (wr_en_i && addr_i == `WSR_OFF_CTRL) ctrl_r <= wr_data_i[5:0];
         if (kick_w || kick_d_r != kick_input_i || (wr_en_i && addr_i == `WSR_OFF_CTRL)) age_r <= 4'h0;
         else if (age_r != 4'hF) age_r <= age_r + 4'h1;
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_pulse_low;
      !sys_reset_n_o [*4];
   endsequence
   chk_off_disabled: assert property (!ctrl_r[0] |=> sys_reset_n_o)
      else $error("reset asserted while disabled");
   chk_level_rise: assert property ($rose(sys_reset_n_o) && ctrl_r[0] && !ctrl_r[1] |-> $past(ok_w))
      else $error("reset released without good rails");
   chk_level_off: assert property (ctrl_r[0] && !ctrl_r[1] && rails_pg_off_i |-> ##[1:2] !sys_reset_n_o)
      else $error("reset not asserted on rail loss");
   chk_pulse_min: assert property ($fell(sys_reset_n_o) && ctrl_r[0] && ctrl_r[1] |-> s_pulse_low)
      else $error("reset pulse too short");
   chk_pulse_width: assert property ($rose(sys_reset_n_o) && ctrl_r[0] && ctrl_r[1] && low_cnt_r != 32'h00000000
      && $past(ok_w) |-> low_cnt_r >= 32'(pw_r) * TICK_CYCLES && low_cnt_r <= (32'(pw_r) + 32'h1) * TICK_CYCLES)
      else $error("reset pulse width wrong");
   chk_rd_idle: assert property (!rd_en_i |=> rd_data_o == 32'h00000000)
      else $error("read data outside its cycle");
   chk_expiry_cause: assert property ($rose(expiry_output_o) |-> ctrl_r[2] && ctrl_r[5])
      else $error("expiry output without enables");
   chk_kick_cmd: assert property (kick_w |-> ##2 !expiry_output_o)
      else $error("kick command did not clear expiry");
   chk_kick_pin: assert property ($changed(kick_input_i) && ctrl_r[2] && ctrl_r[4] |-> ##6 !expiry_output_o)
      else $error("kick pin edge did not clear expiry");
   chk_expiry_hold: assert property ($fell(expiry_output_o) |-> age_r <= 4'h8)
      else $error("expiry cleared without service");
endmodule : wsr_checker
`default_nettype wire

// file: testbench/wsr_host_model.sv
// Host processor model: services the timer through the kick pin.
// Assumes service requests arrive from the bench as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module wsr_host_model (
   // Clock and link
   input wire logic ref_clk_i,
   input wire logic sys_reset_n_i,
   input wire logic kick_req_i,
   output logic kick_pin_o
);
   logic pin_r = 1'b0;
   // A host held in reset cannot service; each toggle is one service
   always_ff @(posedge ref_clk_i) begin
      if (kick_req_i && sys_reset_n_i) pin_r <= ~pin_r;
   end
   assign kick_pin_o = pin_r;
endmodule : wsr_host_model
`default_nettype wire
